// *** logic/baud_gen.sv ***
// Baud rate generator: one tick per bit period.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_regs.svh"

module baud_gen #(
  parameter int CNT_W = 14
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Settings and tick.
  baud_link_if.gen link
);

  // ==========================================================================
  // Elaboration check
  initial begin
    if (CNT_W < 14) begin
      $error("baud_gen: CNT_W too small for 64 x 256 clocks.");
    end
  end

  logic [CNT_W-1:0] count;
  logic tick;
  wire [CNT_W-1:0] factor = CNT_W'((link.speed == uart_ctrl_pkg::SPEED_HIGH) ?
                                     `BAUD_FACTOR_HIGH : `BAUD_FACTOR_LOW);
  wire [CNT_W-1:0] steps = CNT_W'({6'h00, link.divisor}) + CNT_W'(1);
  wire [CNT_W-1:0] last = CNT_W'(factor * steps - CNT_W'(1));
  wire at_last = (count >= last);

  // Free running counter; it is cleared while the link is stopped so that
  // a restart always gives a full first bit period.
  always_ff @(posedge clock_i) begin
    if (rst_i || !link.run) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + CNT_W'(1);
      tick <= at_last;
    end
  end

  assign link.tick = tick;

endmodule : baud_gen

`default_nettype wire

// *** logic/baud_link_if.sv ***
// Interface between the control block and its baud generator.
`timescale 1ns/1ns
`default_nettype none

interface baud_link_if;
  logic run;
  uart_ctrl_pkg::baud_speed_t speed;
  logic [7:0] divisor;
  logic tick;

  // ==========================================================================
  // Control end drives the settings, generator end returns the bit tick.
  modport ctrl (output run, output speed, output divisor, input tick);
  modport gen (input run, input speed, input divisor, output tick);
endinterface : baud_link_if

`default_nettype wire

// *** logic/uart_ctrl.sv ***
// UART second control register block with AXI4-Lite access and interrupt.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_regs.svh"

module uart_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // AXI4-Lite write address and data.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins.
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_own_o,
  output logic rx_pin_own_o,
  // UART core side.
  input wire logic tx_serial_i,
  output logic rx_serial_o,
  output logic tx_active_o,
  output logic rx_active_o,
  output logic nine_bit_o,
  output logic baud_tick_o,
  input wire logic rx_word_valid_i,
  input wire logic [8:0] rx_word_i,
  output logic rx_word_keep_o,
  output logic rx_addr_word_o,
  input wire logic rx_data_ready_i,
  input wire logic overrun_flag_i,
  input wire logic tx_idle_flag_i,
  input wire logic tx_buffer_empty_i,
  // Power management and interrupt.
  input wire logic low_power_idle_i,
  output logic wake_o,
  output logic irq_o
);

  // ==========================================================================
  // Elaboration check
  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("uart_ctrl: ADDR_W must lie between 5 and 32.");
    end
  end

  // ==========================================================================
  // Registers
  logic [7:0] control_two;
  logic [7:0] master_ctrl;
  logic [7:0] baud_divisor;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  wire tx_enable = control_two[`BIT_TX_ENABLE];
  wire rx_enable = control_two[`BIT_RX_ENABLE];
  wire baud_high_speed = control_two[`BIT_BAUD_HIGH_SPEED];
  wire address_detect_on = control_two[`BIT_ADDRESS_DETECT_ON];
  wire wake_enable = control_two[`BIT_WAKE_ENABLE];
  wire rx_irq_enable = control_two[`BIT_RX_IRQ_ENABLE];
  wire tx_idle_irq_enable = control_two[`BIT_TX_IDLE_IRQ_ENABLE];
  wire tx_empty_irq_enable = control_two[`BIT_TX_EMPTY_IRQ_ENABLE];
  wire uart_master_on = master_ctrl[`BIT_UART_MASTER_ON];
  wire nine_bit_select = master_ctrl[`BIT_NINE_BIT_SELECT];

  // ==========================================================================
  // AXI4-Lite write path
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;

  // Address and data are caught in either order; the write happens once both are held.
  wire aw_take = s_axi_awvalid && !aw_held;
  wire w_take = s_axi_wvalid && !w_held;
  wire wr_go = aw_held && w_held && !bvalid;
  wire [7:0] wr_ofs = 8'(aw_addr);
  wire wr_low = wr_go && w_strb[0];
  wire wr_ctl2 = wr_low && (wr_ofs == `OFS_CONTROL_TWO);
  wire wr_mctl = wr_low && (wr_ofs == `OFS_MASTER_CTRL);
  wire wr_baud = wr_low && (wr_ofs == `OFS_BAUD_DIVISOR);
  wire wr_stat = wr_low && (wr_ofs == `OFS_IRQ_STATUS);
  wire wr_mask = wr_low && (wr_ofs == `OFS_IRQ_MASK);
  wire wr_hit = (wr_ofs == `OFS_CONTROL_TWO) || (wr_ofs == `OFS_MASTER_CTRL) ||
                (wr_ofs == `OFS_BAUD_DIVISOR) || (wr_ofs == `OFS_FLAG_VIEW) ||
                (wr_ofs == `OFS_IRQ_STATUS) || (wr_ofs == `OFS_IRQ_MASK);

  // Handshake signals of the write channels.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? uart_ctrl_pkg::RESP_OKAY : uart_ctrl_pkg::RESP_SLVERR;
      end else if (bvalid && s_axi_bready) begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // ==========================================================================
  // Control registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      control_two <= `RST_CONTROL_TWO;
      master_ctrl <= `RST_MASTER_CTRL;
      baud_divisor <= `RST_BAUD_DIVISOR;
      irq_mask <= `RST_IRQ_MASK;
    end else begin
      if (wr_ctl2) begin
        control_two <= w_data[7:0];
      end
      if (wr_mctl) begin
        master_ctrl <= w_data[7:0];
      end
      if (wr_baud) begin
        baud_divisor <= w_data[7:0];
      end
      if (wr_mask) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // ==========================================================================
  // Enables and pin ownership
  // A disabled side is held in reset by the core, which drops any character in flight.
  assign tx_active_o = tx_enable && uart_master_on;
  assign rx_active_o = rx_enable && uart_master_on;
  assign tx_pin_own_o = tx_active_o;
  assign rx_pin_own_o = rx_active_o;
  assign nine_bit_o = nine_bit_select;

  // The RX pin is asynchronous and passes two flip-flops before use.
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic tx_pin;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
      tx_pin <= 1'b1;
    end else begin
      rx_meta <= rx_pin_i;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
      tx_pin <= tx_active_o ? tx_serial_i : 1'b1;
    end
  end

  // An idle line is fed to a stopped receiver so it never sees a false start bit.
  assign rx_serial_o = rx_active_o ? rx_sync : 1'b1;
  assign tx_pin_o = tx_pin;

  // ==========================================================================
  // Baud generator
  baud_link_if baud_link ();
  assign baud_link.run = uart_master_on && (tx_enable || rx_enable);
  assign baud_link.speed = baud_high_speed ? uart_ctrl_pkg::SPEED_HIGH : uart_ctrl_pkg::SPEED_LOW;
  assign baud_link.divisor = baud_divisor;

  baud_gen #(
    .CNT_W(14)
  ) u_baud_gen (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .link(baud_link.gen)
  );

  assign baud_tick_o = baud_link.tick;

  // ==========================================================================
  // Address filter
  wire addr_bit = nine_bit_select ? rx_word_i[8] : rx_word_i[7];
  wire rx_word_in = rx_word_valid_i && rx_active_o;
  assign rx_addr_word_o = rx_word_in && address_detect_on && addr_bit;
  assign rx_word_keep_o = rx_word_in && (!address_detect_on || addr_bit);

  // ==========================================================================
  // Interrupt events
  logic overrun_prev;
  logic ready_prev;
  logic idle_prev;
  logic empty_prev;
  logic wake;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      overrun_prev <= 1'b0;
      ready_prev <= 1'b0;
      idle_prev <= 1'b0;
      empty_prev <= 1'b0;
    end else begin
      overrun_prev <= overrun_flag_i;
      ready_prev <= rx_data_ready_i;
      idle_prev <= tx_idle_flag_i;
      empty_prev <= tx_buffer_empty_i;
    end
  end

  // Under address detection a dropped data word never sets ready, so only kept words count.
  wire rx_event = rx_irq_enable && ((rx_data_ready_i && !ready_prev) || rx_addr_word_o);
  wire ovr_event = rx_irq_enable && overrun_flag_i && !overrun_prev;
  wire idle_event = tx_idle_irq_enable && tx_idle_flag_i && !idle_prev;
  wire empty_event = tx_empty_irq_enable && tx_buffer_empty_i && !empty_prev;
  wire req_set = rx_event || ovr_event || idle_event || empty_event;
  wire wake_set = wake_enable && low_power_idle_i && rx_prev && !rx_sync;
  wire [1:0] stat_set = {wake_set, req_set};
  wire [1:0] stat_clr = wr_stat ? w_data[1:0] : 2'h0;

  // Sticky status flags and a one-cycle wake pulse; a new event in the clearing cycle wins.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
      wake <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~stat_clr) | stat_set;
      wake <= wake_set;
    end
  end

  assign wake_o = wake;
  assign irq_o = |(irq_status & irq_mask);

  // ==========================================================================
  // AXI4-Lite read path
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  wire [7:0] rd_ofs = 8'(s_axi_araddr);
  wire [3:0] flag_view = {rx_data_ready_i, overrun_flag_i, tx_idle_flag_i, tx_buffer_empty_i};
  wire rd_hit = (rd_ofs == `OFS_CONTROL_TWO) || (rd_ofs == `OFS_MASTER_CTRL) ||
                (rd_ofs == `OFS_BAUD_DIVISOR) || (rd_ofs == `OFS_FLAG_VIEW) ||
                (rd_ofs == `OFS_IRQ_STATUS) || (rd_ofs == `OFS_IRQ_MASK);
  wire [7:0] rd_val = (rd_ofs == `OFS_CONTROL_TWO) ? control_two :
                      (rd_ofs == `OFS_MASTER_CTRL) ? master_ctrl :
                      (rd_ofs == `OFS_BAUD_DIVISOR) ? baud_divisor :
                      (rd_ofs == `OFS_FLAG_VIEW) ? {4'h0, flag_view} :
                      (rd_ofs == `OFS_IRQ_STATUS) ? {6'h00, irq_status} :
                      (rd_ofs == `OFS_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;
  wire rd_take = s_axi_arvalid && !rvalid;

  // One read at a time; the address is refused while data waits.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_val};
      rresp <= rd_hit ? uart_ctrl_pkg::RESP_OKAY : uart_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_TX_OFF_IDLE: assert property (!tx_active_o |-> !tx_pin_own_o ##1 tx_pin_o)
    else $error("Transmit pin not idle while transmitter is off.");
  AST_TX_NEEDS_BOTH: assert property (tx_pin_own_o == (tx_enable && uart_master_on))
    else $error("Transmit pin ownership does not follow both enables.");
  AST_TX_ABORT: assert property ($fell(tx_enable) |-> !tx_active_o ##1 tx_pin_o)
    else $error("Clearing transmit enable did not abort the character.");
  AST_RX_OFF_LINE: assert property (!rx_active_o |-> rx_serial_o && !rx_word_keep_o)
    else $error("Stopped receiver still sees line or words.");
  AST_RX_NEEDS_BOTH: assert property (rx_pin_own_o == (rx_enable && uart_master_on))
    else $error("Receive pin ownership does not follow both enables.");
  AST_ADDR_DROP: assert property (rx_word_in && address_detect_on && !addr_bit |-> !rx_word_keep_o)
    else $error("Data word kept under address detection.");
  AST_ADDR_IRQ: assert property (rx_addr_word_o && rx_irq_enable |=> irq_status[`BIT_IRQ_UART_REQ])
    else $error("Address word did not request an interrupt.");
  AST_RX_IRQ_OFF: assert property (!rx_irq_enable && !tx_idle_irq_enable && !tx_empty_irq_enable
                                   && !irq_status[0] && !stat_clr[0] |=> !irq_status[0])
    else $error("Request set with every source disabled.");
  AST_OVR_IRQ: assert property (rx_irq_enable && $rose(overrun_flag_i) |=> irq_status[0])
    else $error("Overrun did not set the request.");
  AST_IDLE_IRQ: assert property (tx_idle_irq_enable && $rose(tx_idle_flag_i) |=> irq_status[0])
    else $error("Transmit idle did not set the request.");
  AST_EMPTY_IRQ: assert property (tx_empty_irq_enable && $rose(tx_buffer_empty_i) |=> irq_status[0])
    else $error("Transmit empty did not set the request.");
  AST_WAKE: assert property (wake_o |-> $past(wake_enable) && $past(low_power_idle_i))
    else $error("Wake without enable or low power mode.");
  AST_SPEED: assert property (baud_link.speed == (baud_high_speed ? uart_ctrl_pkg::SPEED_HIGH
                                                 : uart_ctrl_pkg::SPEED_LOW))
    else $error("Baud speed does not follow the speed bit.");

  // Clocks since the last tick, and whether the settings held still over that period.
  // A long repetition would be unrolled by the tools, so the period is counted here.
  logic [15:0] tick_gap;
  logic gap_clean;
  wire [15:0] gap_factor = baud_high_speed ? 16'(`BAUD_FACTOR_HIGH) : 16'(`BAUD_FACTOR_LOW);
  wire [15:0] gap_want = (16'({8'h00, baud_divisor}) + 16'h0001) * gap_factor;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_gap <= 16'h0000;
      gap_clean <= 1'b0;
    end else begin
      tick_gap <= baud_tick_o ? 16'h0001 : tick_gap + 16'h0001;
      gap_clean <= (baud_tick_o || gap_clean) && $stable(control_two) && $stable(master_ctrl)
                   && $stable(baud_divisor);
    end
  end

  AST_BAUD_PERIOD: assert property (baud_tick_o && gap_clean && $stable(control_two) && $stable(master_ctrl)
                                    && $stable(baud_divisor) |-> tick_gap == gap_want)
    else $error("Bit period is not the speed factor times divisor plus one.");

  COV_WRITE: cover property (wr_ctl2);
  COV_ADDR_WORD: cover property (rx_addr_word_o);
  COV_WAKE: cover property (wake_o);
  COV_IRQ: cover property (irq_o);

endmodule : uart_ctrl

`default_nettype wire

// *** logic/uart_ctrl_pkg.sv ***
// Types shared by the UART control block.
`default_nettype none
package uart_ctrl_pkg;

  // ==========================================================================
  // AXI4-Lite response codes.
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

  // Speed mode of the baud generator.
  typedef enum logic {
    SPEED_LOW,
    SPEED_HIGH
  } baud_speed_t;

endpackage : uart_ctrl_pkg

`default_nettype wire

// *** logic/uart_ctrl_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the UART control block.
`ifndef UART_CTRL_REGS_SVH
`define UART_CTRL_REGS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CONTROL_TWO 8'h00
`define OFS_MASTER_CTRL 8'h04
`define OFS_BAUD_DIVISOR 8'h08
`define OFS_FLAG_VIEW 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// ==========================================================================
// Fields of uart_control_two
`define BIT_TX_ENABLE 7
`define BIT_RX_ENABLE 6
`define BIT_BAUD_HIGH_SPEED 5
`define BIT_ADDRESS_DETECT_ON 4
`define BIT_WAKE_ENABLE 3
`define BIT_RX_IRQ_ENABLE 2
`define BIT_TX_IDLE_IRQ_ENABLE 1
`define BIT_TX_EMPTY_IRQ_ENABLE 0

// Fields of the master control register.
`define BIT_UART_MASTER_ON 7
`define BIT_NINE_BIT_SELECT 6

// Fields of the flag view register.
`define BIT_VIEW_RX_READY 3
`define BIT_VIEW_OVERRUN 2
`define BIT_VIEW_TX_IDLE 1
`define BIT_VIEW_TX_EMPTY 0

// Fields of the interrupt status and mask registers.
`define BIT_IRQ_UART_REQ 0
`define BIT_IRQ_WAKE 1

// ==========================================================================
// Reset values
`define RST_CONTROL_TWO 8'h00
`define RST_MASTER_CTRL 8'h00
`define RST_BAUD_DIVISOR 8'h00
`define RST_IRQ_MASK 2'h0

// ==========================================================================
// Baud generator clocks per bit for one divisor step
`define BAUD_FACTOR_LOW 14'h0040
`define BAUD_FACTOR_HIGH 14'h0010

`endif

// *** tb/serial_node.sv ***
// Remote serial node model that sends frames onto the block's receive pin.
`timescale 1ns/1ns
`default_nettype none

module serial_node #(
  parameter int BIT_CLKS = 16
) (
  // Clock.
  input wire logic clock_i,
  // Line towards the receive pin.
  output var logic line_o
);
  // The line idles high, the level a pulled-up receive line rests at between frames.
  initial line_o = 1'b1;

  // One frame: start bit, eight data bits with the least significant first, one stop bit.
  task automatic send(input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= frame[i];
      repeat (BIT_CLKS) @(posedge clock_i);
    end
  endtask : send
endmodule : serial_node

`default_nettype wire

// *** tb/uart_txrx_enable_irq_control_test.sv ***
// Self-checking testbench of the UART control block.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_regs.svh"

module uart_txrx_enable_irq_control_test;
  // ==========================================================================
  // Design signals
  logic clock_i = 0;
  logic rst_i = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rx_pin_i, tx_serial_i = 1, rx_word_valid_i = 0, low_power_idle_i = 0;
  logic [8:0] rx_word_i = 0;
  logic [3:0] flags = 0;
  logic tx_pin_o, tx_pin_own_o, rx_pin_own_o, rx_serial_o, tx_active_o, rx_active_o, nine_bit_o, baud_tick_o;
  logic rx_word_keep_o, rx_addr_word_o, wake_o, irq_o;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  uart_ctrl dut (.clock_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_pin_i, .tx_pin_o, .tx_pin_own_o, .rx_pin_own_o, .tx_serial_i, .rx_serial_o,
    .tx_active_o, .rx_active_o, .nine_bit_o, .baud_tick_o, .rx_word_valid_i, .rx_word_i,
    .rx_word_keep_o, .rx_addr_word_o, .rx_data_ready_i(flags[3]), .overrun_flag_i(flags[2]),
    .tx_idle_flag_i(flags[1]), .tx_buffer_empty_i(flags[0]), .low_power_idle_i, .wake_o, .irq_o);

  serial_node #(.BIT_CLKS(16)) node (.clock_i, .line_o(rx_pin_i));

  // Free-running clock at 20 MHz.
  always #25 clock_i = ~clock_i;

  // A hang is cut short well above the few thousand cycles the sequence needs.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(negedge clock_i);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge clock_i);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    do @(negedge clock_i); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge clock_i);
    s_axi_bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge clock_i); while (!s_axi_arready);
    @(posedge clock_i);
    s_axi_arvalid <= 0;
    do @(negedge clock_i); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    @(posedge clock_i);
    s_axi_rready <= 0;
  endtask : rd

  // Expected bit period in clocks for a speed mode and divisor.
  function automatic int bit_clks(input logic hi, input logic [7:0] dv);
    return (hi ? 16 : 64) * (int'(dv) + 1);
  endfunction : bit_clks

  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [8:0] w;
    logic a, b, p;
    int n;
    void'($urandom(32'h0a0a_d2be));
    repeat (4) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    // Reset values, an unmapped offset and a read-back of the control register.
    rd(`OFS_CONTROL_TWO, 0, 0);
    rd(`OFS_BAUD_DIVISOR, 0, 0);
    rd(`OFS_IRQ_MASK, 0, 0);
    rd(8'h18, 0, 2);
    wr(8'h18, 32'hff, 2);
    v = 8'($urandom);
    wr(`OFS_CONTROL_TWO, {24'hffff_ff, v}, 0);
    rd(`OFS_CONTROL_TWO, v, 0);
    // Every mix of the two enables and the master bit, counting down from all three set.
    for (int k = 7; k >= 0; k--) begin
      a = k[0] & k[2];
      b = k[1] & k[2];
      wr(`OFS_MASTER_CTRL, {k[2], 7'h00}, 0);
      wr(`OFS_CONTROL_TWO, {k[0], k[1], 6'h00}, 0);
      tx_serial_i <= 0;
      repeat (3) @(negedge clock_i);
      chk(tx_pin_own_o, a);
      chk(tx_active_o, a);
      chk(tx_pin_o, !a);
      chk(rx_pin_own_o, b);
      chk(rx_active_o, b);
      fork
        node.send(8'hff);
        begin
          repeat (10) @(negedge clock_i);
          chk(rx_serial_o, !b);
        end
      join
      tx_serial_i <= 1;
    end
    // Bit period in both speed modes, divisor zero as the corner.
    wr(`OFS_MASTER_CTRL, 32'h80, 0);
    for (int s = 0; s < 4; s++) begin
      v = (s < 2) ? 8'h00 : 8'($urandom % 4);
      wr(`OFS_BAUD_DIVISOR, v, 0);
      wr(`OFS_CONTROL_TWO, {2'b11, s[0], 5'h00}, 0);
      repeat (2) begin
        do @(negedge clock_i); while (!baud_tick_o);
      end
      n = 0;
      do begin
        @(negedge clock_i);
        n++;
      end while (!baud_tick_o);
      chk(n, bit_clks(s[0], v));
      @(posedge clock_i);
    end
    // Each event with its enable off (others on) and on.
    wr(`OFS_IRQ_MASK, 32'h1, 0);
    for (int j = 0; j < 8; j++) begin
      v = (j % 4 >= 2) ? 8'h04 : 8'h01 << (j % 4);
      wr(`OFS_CONTROL_TWO, j[2] ? v : ~v & 8'h07, 0);
      wr(`OFS_IRQ_STATUS, 32'h3, 0);
      flags[j % 4] <= 1;
      repeat (3) @(negedge clock_i);
      chk(irq_o, j[2]);
      @(posedge clock_i);
      rd(`OFS_FLAG_VIEW, 32'h1 << (j % 4), 0);
      flags <= 0;
      rd(`OFS_IRQ_STATUS, j[2], 0);
      wr(`OFS_IRQ_STATUS, 32'h1, 0);
      rd(`OFS_IRQ_STATUS, 0, 0);
    end
    // Address detection in both word formats, detection on with bit 7 or bit 8 of the word set first.
    for (int j = 0; j < 12; j++) begin
      a = 1'($urandom % 2);
      b = (j < 4) ? 1'b1 : 1'($urandom % 2);
      w = (j < 4) ? 9'h080 << j[0] : 9'($urandom);
      p = a ? w[8] : w[7];
      wr(`OFS_MASTER_CTRL, {1'b1, a, 6'h00}, 0);
      wr(`OFS_CONTROL_TWO, {3'b010, b, 4'h4}, 0);
      wr(`OFS_IRQ_STATUS, 32'h3, 0);
      rx_word_i <= w;
      rx_word_valid_i <= 1;
      @(negedge clock_i);
      chk(nine_bit_o, a);
      chk(rx_addr_word_o, b & p);
      chk(rx_word_keep_o, !b | p);
      @(posedge clock_i);
      rx_word_valid_i <= 0;
      repeat (3) @(negedge clock_i);
      chk(irq_o, b & p);
      @(posedge clock_i);
    end
    // Falling receive edge with and without the wake bit, asleep and awake.
    for (int j = 0; j < 4; j++) begin
      wr(`OFS_CONTROL_TWO, {4'h0, j[0], 3'h0}, 0);
      low_power_idle_i <= j[1];
      n = 0;
      fork
        node.send(8'hff);
        repeat (200) begin
          @(negedge clock_i);
          n += wake_o;
        end
      join
      chk(n, j[0] & j[1]);
      @(posedge clock_i);
    end
    finish_test();
  end
endmodule : uart_txrx_enable_irq_control_test

`default_nettype wire
